//--- hw/ssp_regs.vh
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_W              8
`define SSP_IDX_HI         9
`define SSP_IDX_LO         2
`define SSP_IDX_PME_SOURCE_ENABLE_SIX    8'h0F
`define SSP_IDX_STS1       8'h10
`define SSP_IDX_STS2       8'h11
`define SSP_IDX_STS3       8'h12
`define SSP_IDX_STS4       8'h13
`define SSP_IDX_STS5       8'h14
`define SSP_IDX_EN1        8'h16
`define SSP_IDX_EN2        8'h17
`define SSP_IDX_EN3        8'h18
`define SSP_IDX_EN4        8'h19
`define SSP_IDX_EN5        8'h1A
`define SSP_RST_ZERO       8'h00
`define SSP_RST_STS1       8'h02
`define SSP_STS1_PAR_BIT   1
`define SSP_STS1_MASK      8'h9E
`define SSP_STS2_W1C       8'h3C
`define SSP_STS2_MASK      8'h3F
`define SSP_EN1_MASK       8'h9E
`define SSP_EN2_MASK       8'h3F
`define SSP_WORD_ZERO      32'h0000_0000
`endif

//--- hw/ssp_bank.v
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`include "ssp_regs.vh"
module ssp_bank (
   input  wire        CLK_SYS,
   input  wire        RST_N,
   input  wire        MAIN_POWER_ON_RESET,
   input  wire        HARD_RESET,
   input  wire        SOFT_RESET,
   input  wire        WB_CYC,
   input  wire        WB_STB,
   input  wire        WB_WE,
   input  wire [9:0]  WB_ADR,
   input  wire [3:0]  WB_SEL,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK,
   input  wire        PARALLEL_PORT_ACTIVE,
   input  wire        PRINTER_ACK,
   input  wire        SECOND_SERIAL_IRQ,
   input  wire        FIRST_SERIAL_IRQ,
   input  wire        FLOPPY_IRQ,
   input  wire        MOUSE_IRQ,
   input  wire        KEYBOARD_IRQ,
   input  wire        WATCHDOG_EVENT,
   input  wire        SMBUS_EVENT,
   input  wire        FIRST_RING_INDICATE,
   input  wire        SECOND_RING_INDICATE,
   input  wire        KBC_PORT12_EVENT,
   input  wire        FAN_TACHOMETER_EVENT,
   input  wire [2:0]  GPIO_20_22,
   input  wire        GPIO_60,
   input  wire [3:0]  GPIO_24_27,
   input  wire [3:0]  GPIO_30_33,
   input  wire        GPIO_41,
   input  wire        GPIO_43,
   input  wire        GPIO_61,
   input  wire [7:0]  GPIO_50_57,
   input  wire [7:0]  WAKE_EVENT,
   output reg  [7:0]  WAKE_STATUS_BUS,
   output reg         GROUP_SYSMGMT_IRQ
);

   // Sticky status: a set in the clearing cycle wins
   function [`SSP_W-1:0] ssp_w1c;
      input [`SSP_W-1:0] cur;
      input [`SSP_W-1:0] set;
      input [`SSP_W-1:0] clr;
      begin
         ssp_w1c = set | (cur & ~clr);
      end
   endfunction

   reg               rst_meta;
   reg               rst_sync;
   reg [`SSP_W-1:0]  pme_source_enable_six;
   reg [`SSP_W-1:0]  sts1;
   reg [`SSP_W-1:0]  sts2;
   reg [`SSP_W-1:0]  sts3;
   reg [`SSP_W-1:0]  sts4;
   reg [`SSP_W-1:0]  sts5;
   reg [`SSP_W-1:0]  en1;
   reg [`SSP_W-1:0]  en2;
   reg [`SSP_W-1:0]  en3;
   reg [`SSP_W-1:0]  en4;
   reg [`SSP_W-1:0]  en5;
   reg [`SSP_W-1:0]  next_sts1;
   reg [`SSP_W-1:0]  next_sts2;
   reg [`SSP_W-1:0]  rd_byte;
   reg [`SSP_W-1:0]  clr2;
   reg [`SSP_W-1:0]  clr3;
   reg [`SSP_W-1:0]  clr4;
   reg [`SSP_W-1:0]  clr5;

   wire              req;
   wire              wr;
   wire [7:0]        idx;
   wire [`SSP_W-1:0] wdat;
   wire              warm_reset;
   wire [`SSP_W-1:0] src3;
   wire [`SSP_W-1:0] src4;
   wire [`SSP_W-1:0] src5;
   wire              group;

   assign req  = WB_CYC & WB_STB & ~WB_ACK;
   // Byte lane 0 carries each register; other lanes ignored
   assign wr   = req & WB_WE & WB_SEL[0];
   assign idx  = WB_ADR[`SSP_IDX_HI:`SSP_IDX_LO];
   assign wdat = WB_DAT_I[`SSP_W-1:0];
   assign warm_reset = MAIN_POWER_ON_RESET | HARD_RESET | SOFT_RESET;

   assign src3 = {GPIO_24_27, GPIO_60, GPIO_20_22};
   assign src4 = {GPIO_61, GPIO_43, FAN_TACHOMETER_EVENT,
                  GPIO_41, GPIO_30_33};
   assign src5 = GPIO_50_57;

   // Standby reset released through two stages
   always @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   always @* begin
      next_sts1 = `SSP_RST_ZERO;
      // Level sources; writes have no path in here
      next_sts1[`SSP_STS1_PAR_BIT] =
         PARALLEL_PORT_ACTIVE ? PRINTER_ACK : 1'b1;
      next_sts1[2] = SECOND_SERIAL_IRQ;
      next_sts1[3] = FIRST_SERIAL_IRQ;
      next_sts1[4] = FLOPPY_IRQ;
      next_sts1[7] = WATCHDOG_EVENT;
      if (warm_reset)
         next_sts1[`SSP_STS1_PAR_BIT] = 1'b1;
      next_sts1 = next_sts1 & `SSP_STS1_MASK;
   end

   always @* begin
      clr2 = `SSP_RST_ZERO;
      clr3 = `SSP_RST_ZERO;
      clr4 = `SSP_RST_ZERO;
      clr5 = `SSP_RST_ZERO;
      if (wr) begin
         case (idx)
            `SSP_IDX_STS2: clr2 = wdat & `SSP_STS2_W1C;
            `SSP_IDX_STS3: clr3 = wdat;
            `SSP_IDX_STS4: clr4 = wdat;
            `SSP_IDX_STS5: clr5 = wdat;
            default: clr2 = `SSP_RST_ZERO;
         endcase
      end
   end

   always @* begin
      next_sts2 = ssp_w1c(sts2,
         {2'b00, SECOND_RING_INDICATE, KBC_PORT12_EVENT,
          FIRST_RING_INDICATE, SMBUS_EVENT, 2'b00}, clr2);
      // Mouse and keyboard track their source levels
      next_sts2[0] = MOUSE_IRQ;
      next_sts2[1] = KEYBOARD_IRQ;
      next_sts2 = next_sts2 & `SSP_STS2_MASK;
   end

   always @* begin
      case (idx)
         `SSP_IDX_PME_SOURCE_ENABLE_SIX: rd_byte = pme_source_enable_six;
         `SSP_IDX_STS1:    rd_byte = sts1;
         `SSP_IDX_STS2:    rd_byte = sts2;
         `SSP_IDX_STS3:    rd_byte = sts3;
         `SSP_IDX_STS4:    rd_byte = sts4;
         `SSP_IDX_STS5:    rd_byte = sts5;
         `SSP_IDX_EN1:     rd_byte = en1;
         `SSP_IDX_EN2:     rd_byte = en2;
         `SSP_IDX_EN3:     rd_byte = en3;
         `SSP_IDX_EN4:     rd_byte = en4;
         `SSP_IDX_EN5:     rd_byte = en5;
         default:          rd_byte = `SSP_RST_ZERO;
      endcase
   end

   assign group = |(sts1 & en1) | |(sts2 & en2) | |(sts3 & en3)
                | |(sts4 & en4) | |(sts5 & en5);

   // Status and enable registers
   always @(posedge CLK_SYS or negedge rst_sync) begin
      if (!rst_sync) begin
         pme_source_enable_six <= `SSP_RST_ZERO;
         sts1    <= `SSP_RST_STS1;
         sts2    <= `SSP_RST_ZERO;
         sts3    <= `SSP_RST_ZERO;
         sts4    <= `SSP_RST_ZERO;
         sts5    <= `SSP_RST_ZERO;
         en1     <= `SSP_RST_ZERO;
         en2     <= `SSP_RST_ZERO;
         en3     <= `SSP_RST_ZERO;
         en4     <= `SSP_RST_ZERO;
         en5     <= `SSP_RST_ZERO;
      end else begin
         sts1 <= next_sts1;
         sts2 <= next_sts2;
         sts3 <= ssp_w1c(sts3, src3, clr3);
         sts4 <= ssp_w1c(sts4, src4, clr4);
         sts5 <= ssp_w1c(sts5, src5, clr5);
         if (wr) begin
            case (idx)
               `SSP_IDX_PME_SOURCE_ENABLE_SIX: pme_source_enable_six <= wdat;
               `SSP_IDX_EN1: en1 <= wdat & `SSP_EN1_MASK;
               `SSP_IDX_EN2: en2 <= wdat & `SSP_EN2_MASK;
               `SSP_IDX_EN3: en3 <= wdat;
               `SSP_IDX_EN4: en4 <= wdat;
               `SSP_IDX_EN5: en5 <= wdat;
               default: en5 <= en5;
            endcase
         end
      end
   end

   // Bus answer and outputs, all registered
   always @(posedge CLK_SYS or negedge rst_sync) begin
      if (!rst_sync) begin
         WB_ACK            <= 1'b0;
         WB_DAT_O          <= `SSP_WORD_ZERO;
         WAKE_STATUS_BUS   <= `SSP_RST_ZERO;
         GROUP_SYSMGMT_IRQ <= 1'b0;
      end else begin
         // Unmapped index still acked, reads zero
         WB_ACK   <= req;
         WB_DAT_O <= {24'h000000, rd_byte};
         WAKE_STATUS_BUS   <= pme_source_enable_six & WAKE_EVENT;
         GROUP_SYSMGMT_IRQ <= group;
      end
   end

endmodule // ssp_bank

//--- verif/ssp_bank_properties.sv
`timescale 1ns/1ns
module ssp_bank_properties (
   input wire        CLK_SYS,
   input wire        RST_N,
   input wire        WB_CYC,
   input wire        WB_STB,
   input wire        WB_WE,
   input wire [9:0]  WB_ADR,
   input wire [31:0] WB_DAT_O,
   input wire        WB_ACK,
   input wire [7:0]  WAKE_EVENT,
   input wire [7:0]  WAKE_STATUS_BUS
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire rd = WB_CYC && WB_STB && !WB_WE;
   AST_WAKE_GATE: assert property (
      (WAKE_STATUS_BUS & ~$past(WAKE_EVENT)) == 8'h00) else $error("wake");
   AST_ACK_NEXT: assert property (
      WB_CYC && WB_STB && !WB_ACK |=> WB_ACK) else $error("no ack");
   AST_ACK_PULSE: assert property (
      WB_ACK |=> !WB_ACK) else $error("long ack");
   AST_ACK_CAUSE: assert property (
      $rose(WB_ACK) |-> $past(WB_CYC && WB_STB)) else $error("stray ack");
   AST_DAT_UPPER: assert property (
      WB_ACK |-> WB_DAT_O[31:8] == 24'h0) else $error("upper data");
   AST_STS1_RSV: assert property (
      WB_ACK && $past(rd && WB_ADR[9:2] == 8'h10)
      |-> (WB_DAT_O & 32'hFFFF_FF61) == 0) else $error("sts1 reserved");
   AST_STS2_RSV: assert property (
      WB_ACK && $past(rd && WB_ADR[9:2] == 8'h11)
      |-> (WB_DAT_O & 32'hFFFF_FFC0) == 0) else $error("sts2 reserved");
   AST_UNMAPPED: assert property (
      WB_ACK && $past(rd && WB_ADR[9:2] == 8'h20)
      |-> WB_DAT_O == 0) else $error("unmapped read");
   cover property (WB_ACK && WB_WE);
   cover property (WAKE_STATUS_BUS != 8'h00);
   cover property (WB_ACK && !WB_WE);
endmodule // ssp_bank_properties
bind ssp_bank ssp_bank_properties u_props (.CLK_SYS, .RST_N, .WB_CYC,
   .WB_STB, .WB_WE, .WB_ADR, .WB_DAT_O, .WB_ACK, .WAKE_EVENT,
   .WAKE_STATUS_BUS);

//--- verif/test_smi_status_pme_enable_bank.sv
`timescale 1ns/1ns
module test_smi_status_pme_enable_bank;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
   logic        par = 0, pk = 0;
   logic [2:0]  wr3 = 0;
   logic [9:0]  adr = 0;
   logic [3:0]  sel = 4'hF, u = 0;
   logic [5:0]  m = 0;
   logic [31:0] wd = 0, seed = 63573;
   logic [7:0]  g3 = 0, g4 = 0, g5 = 0, wev = 0, en, v, x, gv[3];
   wire  [31:0] rdat;
   wire         ack, irq;
   wire  [7:0]  wsb;
   logic [7:0]  q[$];
   int          n_errors = 0, cmp_count = 0;
   ssp_bank dut_u (.CLK_SYS(clk), .RST_N(rst_n), .MAIN_POWER_ON_RESET(wr3[0]),
      .HARD_RESET(wr3[1]), .SOFT_RESET(wr3[2]), .WB_CYC(cyc), .WB_STB(stb),
      .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_DAT_I(wd),
      .WB_DAT_O(rdat), .WB_ACK(ack), .PARALLEL_PORT_ACTIVE(par),
      .PRINTER_ACK(pk), .SECOND_SERIAL_IRQ(u[0]), .FIRST_SERIAL_IRQ(u[1]),
      .FLOPPY_IRQ(u[2]), .WATCHDOG_EVENT(u[3]), .MOUSE_IRQ(m[0]),
      .KEYBOARD_IRQ(m[1]), .SMBUS_EVENT(m[2]), .FIRST_RING_INDICATE(m[3]),
      .KBC_PORT12_EVENT(m[4]), .SECOND_RING_INDICATE(m[5]),
      .FAN_TACHOMETER_EVENT(g4[5]), .GPIO_20_22(g3[2:0]), .GPIO_60(g3[3]),
      .GPIO_24_27(g3[7:4]), .GPIO_30_33(g4[3:0]), .GPIO_41(g4[4]),
      .GPIO_43(g4[6]), .GPIO_61(g4[7]), .GPIO_50_57(g5), .WAKE_EVENT(wev),
      .WAKE_STATUS_BUS(wsb), .GROUP_SYSMGMT_IRQ(irq));
   always #25 clk = ~clk;
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task chk(input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task wb(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= {i, 2'b00};
      wd <= {24'h0, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 0;
      stb <= 0;
   endtask
   task rd(input logic [7:0] i, input logic [7:0] e);
      q.push_back(e);
      wb(0, i, 0);
   endtask
   // Read data is taken only at the ack edge, while we is still held
   always @(posedge clk)
      if (ack === 1'b1 && we === 1'b0) chk(rdat[7:0], q.pop_front());
   task final_report();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      for (int i = 15; i < 21; i++) rd(i, i == 16 ? 8'h02 : 8'h00);
      for (int k = 0; k < 8; k++) begin
         en = k == 0 ? 8'h00 : rnd();
         wb(1, 8'h0F, en);
         rd(8'h0F, en);
         wev <= rnd();
         repeat (2) @(posedge clk);
         chk(wsb, en & wev);
      end
      for (int k = 0; k < 6; k++) begin
         x = rnd();
         par <= x[0];
         pk <= x[1];
         u <= x[5:2];
         v = {x[5], 2'b00, x[4:2], x[0] ? x[1] : 1'b1, 1'b0};
         rd(8'h10, v);
         wb(1, 8'h10, 8'hFF);
         rd(8'h10, v);
      end
      // Active port with ack low: only a warm reset can raise bit 1
      par <= 1;
      pk <= 0;
      u <= 0;
      for (int k = 0; k < 3; k++) begin
         wr3 <= 3'b001 << k;
         rd(8'h10, 8'h02);
         wr3 <= 3'b000;
         rd(8'h10, 8'h00);
      end
      wb(1, 8'h16, 8'hFF);
      rd(8'h16, 8'h9E);
      chk({7'h0, irq}, 8'h00);
      pk <= 1;
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h01);
      pk <= 0;
      repeat (3) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      m <= 6'h3F;
      @(posedge clk);
      m <= 6'h02;
      rd(8'h11, 8'h3E);
      wb(1, 8'h11, 8'hFF);
      rd(8'h11, 8'h02);
      m <= 0;
      for (int j = 0; j < 3; j++) gv[j] = rnd() | 8'h01;
      {g3, g4, g5} <= {gv[0], gv[1], gv[2]};
      @(posedge clk);
      {g3, g4, g5} <= 24'h0;
      sel <= 4'h0;
      wb(1, 8'h12, 8'hFF);
      sel <= 4'hF;
      for (int j = 0; j < 3; j++) begin
         x = rnd();
         rd(8'h12 + j, gv[j]);
         chk({7'h0, irq}, 8'h00);
         wb(1, 8'h18 + j, gv[j]);
         repeat (2) @(posedge clk);
         chk({7'h0, irq}, 8'h01);
         wb(1, 8'h12 + j, x);
         rd(8'h12 + j, gv[j] & ~x);
         wb(1, 8'h12 + j, 8'hFF);
         repeat (2) @(posedge clk);
         chk({7'h0, irq}, 8'h00);
      end
      wb(1, 8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      repeat (2) @(posedge clk);
      final_report();
   end
endmodule // test_smi_status_pme_enable_bank
